// *** rtl/lbs_pkg.sv ***
// shared types and constants of the loop and breakpoint sequencer
// assumes one clock domain and instructions already split into fields
package lbs_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;
   localparam int NREG = 32;
   localparam int REG_IDX_W = 5;
   localparam int MUL_CNT_W = 5;
   localparam logic [MUL_CNT_W-1:0] MUL_CYCLES = 5'h16;
   localparam logic [MUL_CNT_W-1:0] MUL_LAST = 5'h01;
   localparam logic [MUL_CNT_W-1:0] MUL_STEP = 5'h01;
   localparam logic [ADDR_W-1:0] MUL_WORDS = 10'h007;
   localparam logic [ADDR_W-1:0] PC_STEP = 10'h001;
   localparam logic [ADDR_W-1:0] LOOP_STEP = 10'h001;
   localparam logic [ADDR_W-1:0] ZERO_ADDR = 10'h000;
   localparam logic [DATA_W-1:0] ZERO_DATA = 16'h0000;
   localparam logic [DATA_W-1:0] MOST_NEG = 16'h8000;

   typedef enum logic [3:0] {
      FLOW_CONTINUE = 4'h0,
      FLOW_JUMP = 4'h1,
      FLOW_JUMP_LOOP_PTR = 4'h2,
      FLOW_CALL_LOOP_PTR = 4'h3,
      FLOW_LOOP_NZ = 4'h4,
      FLOW_LOAD_BREAK_IMM = 4'h5,
      FLOW_LOAD_BREAK_COMP = 4'h6,
      FLOW_LOAD_LOOP_IMM = 4'h7,
      FLOW_LOAD_LOOP_COMP = 4'h8,
      FLOW_POP_LOOP = 4'h9
   } lbs_flow_t;

   typedef enum logic [1:0] {
      CPU_NONE = 2'h0,
      CPU_COPY = 2'h1,
      CPU_NEGATE = 2'h2,
      CPU_MULTIPLY = 2'h3
   } lbs_cpu_t;

   typedef enum logic [3:0] {
      OPR_GEN = 4'h0,
      OPR_Q = 4'h1,
      OPR_CONST = 4'h2,
      OPR_IO_IN = 4'h3,
      OPR_AUX_IN = 4'h4,
      OPR_SWAP = 4'h5,
      OPR_DATA_IN = 4'h6,
      OPR_ACC_HI = 4'h7,
      OPR_ACC_LO = 4'h8,
      OPR_BLOCK = 4'h9,
      OPR_AUX_OUT = 4'hA,
      OPR_DATA_OUT = 4'hB,
      OPR_IO_OUT = 4'hC
   } lbs_opr_t;

   typedef struct packed {
      lbs_flow_t flow;
      lbs_cpu_t cpu;
      lbs_opr_t dst_sel;
      logic [REG_IDX_W-1:0] dst_idx;
      lbs_opr_t src_sel;
      logic [REG_IDX_W-1:0] src_idx;
      logic [REG_IDX_W-1:0] src2_idx;
      logic single_form;
      logic [ADDR_W-1:0] imm_addr;
      logic [DATA_W-1:0] constant;
      logic [DATA_W-1:0] out_value;
   } lbs_instr_t;

   typedef struct packed {
      logic zero;
      logic carry;
      logic sign;
      logic overflow;
   } lbs_flags_t;

   typedef struct packed {
      logic [DATA_W-1:0] io_input;
      logic [DATA_W-1:0] aux_input;
      logic [DATA_W-1:0] swap_value;
      logic [DATA_W-1:0] data_input;
   } lbs_ext_in_t;

   typedef struct packed {
      logic [DATA_W-1:0] result;
      lbs_flags_t flags;
   } lbs_alu_out_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_MUL = 2'b10
   } lbs_state_t;
endpackage : lbs_pkg

// *** rtl/lbs_alu.sv ***
// combinational operand unit: copy, two's complement and the idle and-with-zero
// assumes the caller picks the operand and decides where the result goes
`timescale 1ns/1ns
module lbs_alu (
   input wire lbs_pkg::lbs_cpu_t op,
   input wire logic [lbs_pkg::DATA_W-1:0] operand,
   output lbs_pkg::lbs_alu_out_t alu_out
);
   import lbs_pkg::*;

   always_comb begin
      alu_out = '0;
      case (op)
         CPU_COPY: begin
            alu_out.result = operand;
            alu_out.flags.zero = (operand == ZERO_DATA);
            alu_out.flags.sign = operand[DATA_W-1];
         end
         CPU_NEGATE: begin
            alu_out.result = DATA_W'(ZERO_DATA - operand);
            alu_out.flags.zero = (operand == ZERO_DATA);
            alu_out.flags.carry = (operand == ZERO_DATA);
            alu_out.flags.sign = alu_out.result[DATA_W-1];
            alu_out.flags.overflow = (operand == MOST_NEG);
         end
         default: begin
            // no operation coded: and with zero gives zero, sets zero and carry
            alu_out.result = ZERO_DATA;
            alu_out.flags.zero = 1'b1;
            alu_out.flags.carry = 1'b1;
         end
      endcase
   end
endmodule : lbs_alu

// *** rtl/lbs_mul.sv ***
// multiply macro timer: holds the product and signals the last macro cycle
// assumes start is raised for one cycle and not again until done
`timescale 1ns/1ns
module lbs_mul (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic [lbs_pkg::DATA_W-1:0] factor_a,
   input wire logic [lbs_pkg::DATA_W-1:0] factor_b,
   output logic done,
   output logic [2*lbs_pkg::DATA_W-1:0] product
);
   import lbs_pkg::*;

   typedef struct packed {
      logic [MUL_CNT_W-1:0] count;
      logic [2*DATA_W-1:0] product;
   } lbs_mul_state_t;

   lbs_mul_state_t m_q;
   lbs_mul_state_t m_d;

   // the product is formed at once; the counter only models the macro's length
   always_comb begin
      m_d = m_q;
      if (start) begin
         m_d.count = MUL_CYCLES - MUL_STEP;
         m_d.product = (2*DATA_W)'(factor_a) * (2*DATA_W)'(factor_b);
      end else if (m_q.count != '0) begin
         m_d.count = m_q.count - MUL_STEP;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         m_q <= '0;
      end else begin
         m_q <= m_d;
      end
   end

   assign done = (m_q.count == MUL_LAST);
   assign product = m_q.product;
endmodule : lbs_mul

// *** rtl/lbs_sequencer.sv ***
// program-flow, loop, breakpoint and operand-move part of the sequencer
// assumes one decoded instruction per cycle, taken while busy is low
//
// How it works
// - immediate breakpoint load, flags still follow the word's cpu part
// - computed breakpoint load takes cpu result
// - immediate loop count load, flags still follow the word's cpu part
// - computed loop count load takes cpu result
// - loop counter also serves as jump pointer
// - loop if nonzero branches on counter test
// - counter decrements after the test
// - copy selected source into selected destination
// - copy and negate update the flags
// - negate forms two's complement
// - multiply runs 22 cycles, seven words
// - flow, cpu and output act together, except that a multiply word ignores its flow
// - output value drives lines from the next cycle until another word is taken
// - no cpu op means and with zero
// - pointer jump loads full ten bits
`timescale 1ns/1ns
module lbs_sequencer (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic instr_valid,
   input wire lbs_pkg::lbs_instr_t instr,
   input wire lbs_pkg::lbs_ext_in_t ext_in,
   input wire logic [lbs_pkg::ADDR_W-1:0] popped_loop_count,
   input wire logic data_output_taken,
   output logic busy,
   output logic [lbs_pkg::ADDR_W-1:0] program_counter,
   output logic [lbs_pkg::DATA_W-1:0] control_out,
   output logic [lbs_pkg::ADDR_W-1:0] break_point,
   output logic [lbs_pkg::ADDR_W-1:0] loop_counter,
   output lbs_pkg::lbs_flags_t arithmetic_flags,
   output logic accumulator_overflow_flag,
   output logic block_counter_zero_flag,
   output logic [lbs_pkg::DATA_W-1:0] data_output_register,
   output logic data_output_full,
   output logic [lbs_pkg::DATA_W-1:0] io_output_register,
   output logic [lbs_pkg::DATA_W-1:0] aux_output_register,
   output logic call_strobe,
   output logic [lbs_pkg::ADDR_W-1:0] return_address
);
   import lbs_pkg::*;

   typedef struct packed {
      lbs_state_t state;
      logic [ADDR_W-1:0] pc;
      logic [ADDR_W-1:0] break_point;
      logic [ADDR_W-1:0] loop_counter;
      logic [NREG-1:0][DATA_W-1:0] gen;
      logic [DATA_W-1:0] q;
      logic [DATA_W-1:0] acc_hi;
      logic [DATA_W-1:0] acc_lo;
      logic [DATA_W-1:0] block;
      logic [DATA_W-1:0] data_out;
      logic [DATA_W-1:0] io_out;
      logic [DATA_W-1:0] aux_out;
      lbs_flags_t flags;
      logic acc_ovf;
      logic block_zero;
      logic data_full;
      logic [DATA_W-1:0] control_out;
      logic call_strobe;
      logic [ADDR_W-1:0] return_addr;
      logic [REG_IDX_W-1:0] mul_hi_idx;
      logic [REG_IDX_W-1:0] mul_lo_idx;
   } lbs_seq_state_t;

   lbs_seq_state_t s_q;
   lbs_seq_state_t s_d;
   logic [DATA_W-1:0] operand;
   lbs_alu_out_t alu_out;
   logic mul_start;
   logic mul_done;
   logic [2*DATA_W-1:0] mul_product;
   logic take;

   // one read path serves source and the single-form destination operand
   function automatic logic [DATA_W-1:0] read_operand(
      input lbs_seq_state_t s,
      input lbs_opr_t sel,
      input logic [REG_IDX_W-1:0] idx,
      input logic [DATA_W-1:0] constant,
      input lbs_ext_in_t ext
   );
      logic [DATA_W-1:0] v;
      v = ZERO_DATA;
      case (sel)
         OPR_GEN: v = s.gen[idx];
         OPR_Q: v = s.q;
         OPR_CONST: v = constant;
         OPR_IO_IN: v = ext.io_input;
         OPR_AUX_IN: v = ext.aux_input;
         OPR_SWAP: v = ext.swap_value;
         OPR_DATA_IN: v = ext.data_input;
         OPR_ACC_HI: v = s.acc_hi;
         OPR_ACC_LO: v = s.acc_lo;
         OPR_BLOCK: v = s.block;
         OPR_AUX_OUT: v = s.aux_out;
         OPR_DATA_OUT: v = s.data_out;
         OPR_IO_OUT: v = s.io_out;
         default: v = ZERO_DATA;
      endcase
      return v;
   endfunction : read_operand

   assign take = instr_valid && (s_q.state == ST_RUN);

   always_comb begin
      if (instr.single_form) begin
         operand = read_operand(s_q, instr.dst_sel, instr.dst_idx, instr.constant, ext_in);
      end else begin
         operand = read_operand(s_q, instr.src_sel, instr.src_idx, instr.constant, ext_in);
      end
   end

   lbs_alu u_alu (
      .op(instr.cpu),
      .operand(operand),
      .alu_out(alu_out)
   );

   lbs_mul u_mul (
      .clock(clock),
      .sys_rst(sys_rst),
      .start(mul_start),
      .factor_a(s_q.gen[instr.src_idx]),
      .factor_b(s_q.gen[instr.src2_idx]),
      .done(mul_done),
      .product(mul_product)
   );

   always_comb begin
      s_d = s_q;
      mul_start = 1'b0;
      s_d.call_strobe = 1'b0;
      if (data_output_taken) begin
         s_d.data_full = 1'b0;
      end
      case (s_q.state)
         ST_RUN: begin
            if (take) begin
               // output lines carry this word's value from the next cycle until another word is taken
               s_d.control_out = instr.out_value;
               s_d.pc = ADDR_W'(s_q.pc + PC_STEP);
               if (instr.cpu == CPU_MULTIPLY) begin
                  mul_start = 1'b1;
                  s_d.state = ST_MUL;
                  s_d.pc = s_q.pc;
                  s_d.mul_hi_idx = instr.dst_idx;
                  s_d.mul_lo_idx = instr.src_idx;
               end else begin
                  // flags follow the cpu part, including the idle and-with-zero
                  s_d.flags = alu_out.flags;
                  if (instr.cpu != CPU_NONE) begin
                     case (instr.dst_sel)
                        OPR_GEN: s_d.gen[instr.dst_idx] = alu_out.result;
                        OPR_Q: s_d.q = alu_out.result;
                        OPR_ACC_HI: begin
                           s_d.acc_hi = alu_out.result;
                           s_d.acc_ovf = alu_out.flags.overflow;
                        end
                        OPR_ACC_LO: begin
                           s_d.acc_lo = alu_out.result;
                           s_d.acc_ovf = alu_out.flags.overflow;
                        end
                        OPR_BLOCK: begin
                           s_d.block = alu_out.result;
                           s_d.block_zero = (alu_out.result == ZERO_DATA);
                        end
                        OPR_DATA_OUT: begin
                           s_d.data_out = alu_out.result;
                           // a write in the cycle it is taken keeps the flag set
                           s_d.data_full = 1'b1;
                        end
                        OPR_IO_OUT: s_d.io_out = alu_out.result;
                        OPR_AUX_OUT: s_d.aux_out = alu_out.result;
                        default: s_d.q = s_q.q;
                     endcase
                  end
                  case (instr.flow)
                     FLOW_JUMP: s_d.pc = instr.imm_addr;
                     FLOW_JUMP_LOOP_PTR: begin
                        s_d.pc = s_q.loop_counter;
                     end
                     FLOW_CALL_LOOP_PTR: begin
                        // the return address goes out to the stack owner
                        s_d.pc = s_q.loop_counter;
                        s_d.call_strobe = 1'b1;
                        s_d.return_addr = ADDR_W'(s_q.pc + PC_STEP);
                     end
                     FLOW_LOOP_NZ: begin
                        if (s_q.loop_counter != ZERO_ADDR) begin
                           s_d.pc = instr.imm_addr;
                        end
                        // decrement after the test; zero wraps to the top value
                        s_d.loop_counter = ADDR_W'(s_q.loop_counter - LOOP_STEP);
                     end
                     FLOW_LOAD_BREAK_IMM: s_d.break_point = instr.imm_addr;
                     FLOW_LOAD_BREAK_COMP: begin
                        // result of this same word's cpu part, low bits only
                        s_d.break_point = alu_out.result[ADDR_W-1:0];
                     end
                     FLOW_LOAD_LOOP_IMM: s_d.loop_counter = instr.imm_addr;
                     FLOW_LOAD_LOOP_COMP: begin
                        s_d.loop_counter = alu_out.result[ADDR_W-1:0];
                     end
                     FLOW_POP_LOOP: s_d.loop_counter = popped_loop_count;
                     default: s_d.pc = s_d.pc;
                  endcase
               end
            end
         end
         ST_MUL: begin
            // control outputs hold their value for the whole macro
            if (mul_done) begin
               s_d.gen[s_q.mul_lo_idx] = mul_product[DATA_W-1:0];
               s_d.gen[s_q.mul_hi_idx] = mul_product[2*DATA_W-1:DATA_W];
               s_d.flags.zero = (mul_product == '0);
               s_d.flags.carry = 1'b0;
               s_d.flags.sign = mul_product[2*DATA_W-1];
               s_d.flags.overflow = 1'b0;
               s_d.pc = ADDR_W'(s_q.pc + MUL_WORDS);
               s_d.state = ST_RUN;
            end
         end
         default: s_d.state = ST_RUN;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.state <= ST_RUN;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy = (s_q.state == ST_MUL);
   assign program_counter = s_q.pc;
   assign control_out = s_q.control_out;
   assign break_point = s_q.break_point;
   assign loop_counter = s_q.loop_counter;
   assign arithmetic_flags = s_q.flags;
   assign accumulator_overflow_flag = s_q.acc_ovf;
   assign block_counter_zero_flag = s_q.block_zero;
   assign data_output_register = s_q.data_out;
   assign data_output_full = s_q.data_full;
   assign io_output_register = s_q.io_out;
   assign aux_output_register = s_q.aux_out;
   assign call_strobe = s_q.call_strobe;
   assign return_address = s_q.return_addr;
endmodule : lbs_sequencer

// *** bench/lbs_sequencer_props.sv ***
// concurrent checks on the ports of the loop and breakpoint sequencer
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
module lbs_sequencer_props
   import lbs_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic instr_valid,
   input wire lbs_pkg::lbs_instr_t instr,
   input wire logic busy,
   input wire logic [lbs_pkg::ADDR_W-1:0] program_counter,
   input wire logic [lbs_pkg::DATA_W-1:0] control_out,
   input wire logic [lbs_pkg::ADDR_W-1:0] break_point,
   input wire logic [lbs_pkg::ADDR_W-1:0] loop_counter,
   input wire lbs_pkg::lbs_flags_t arithmetic_flags
);
   logic taken;
   logic flow_ok;
   // a multiply word ignores its flow field, so flow checks skip it
   assign taken = instr_valid && !busy;
   assign flow_ok = taken && instr.cpu != CPU_MULTIPLY;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_out_follows: assert property (taken |=> control_out == $past(instr.out_value))
      else $error("control out not the value of the taken word");
   a_busy_holds: assert property (busy |=> $stable(control_out) && $stable(loop_counter))
      else $error("outputs moved during multiply");
   a_mul_timing: assert property (taken && instr.cpu == CPU_MULTIPLY |=> busy[*8] ##1 busy[*8]
      ##1 busy[*5] ##1 (!busy && program_counter == $past(program_counter, 22) + MUL_WORDS))
      else $error("multiply length or word count wrong");
   a_break_imm: assert property (flow_ok && instr.flow == FLOW_LOAD_BREAK_IMM
      |=> break_point == $past(instr.imm_addr))
      else $error("breakpoint immediate load wrong");
   a_loop_imm: assert property (flow_ok && instr.flow == FLOW_LOAD_LOOP_IMM
      |=> loop_counter == $past(instr.imm_addr))
      else $error("loop count immediate load wrong");
   a_loop_dec: assert property (flow_ok && instr.flow == FLOW_LOOP_NZ
      |=> loop_counter == $past(loop_counter) - LOOP_STEP)
      else $error("loop counter not decremented");
   a_loop_branch: assert property (flow_ok && instr.flow == FLOW_LOOP_NZ
      |=> program_counter == ($past(loop_counter) != ZERO_ADDR ?
      $past(instr.imm_addr) : $past(program_counter) + PC_STEP))
      else $error("loop branch target wrong");
   a_ptr_jump: assert property (flow_ok && instr.flow == FLOW_JUMP_LOOP_PTR
      |=> program_counter == $past(loop_counter))
      else $error("pointer jump target wrong");
   a_idle_flags: assert property (taken && instr.cpu == CPU_NONE |=> arithmetic_flags == 4'hC)
      else $error("idle operation flags wrong");
   a_reset_clears: assert property (@(posedge clock) disable iff (1'b0)
      sys_rst |=> !busy && control_out == ZERO_DATA && program_counter == ZERO_ADDR)
      else $error("reset left outputs set");
endmodule : lbs_sequencer_props

bind lbs_sequencer lbs_sequencer_props u_props (.clock(clock), .sys_rst(sys_rst),
   .instr_valid(instr_valid), .instr(instr), .busy(busy), .program_counter(program_counter),
   .control_out(control_out), .break_point(break_point), .loop_counter(loop_counter),
   .arithmetic_flags(arithmetic_flags));

// *** bench/lbs_far_side.sv ***
// model of the logic that consumes the data output register
// assumes the sequencer clock; takes the word a few cycles late on purpose
`timescale 1ns/1ns
module lbs_far_side (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic data_output_full,
   output logic data_output_taken
);
   logic [1:0] wait_q;
   // a slow reader, so the full flag must stand for several cycles
   always_ff @(posedge clock) begin
      data_output_taken <= 1'b0;
      if (sys_rst || !data_output_full) begin
         wait_q <= 2'h0;
      end else if (wait_q == 2'h3) begin
         data_output_taken <= 1'b1;
         wait_q <= 2'h0;
      end else begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule : lbs_far_side

// *** bench/lbs_sequencer_bench.sv ***
// self-checking bench of the loop and breakpoint sequencer
// assumes the far-side model drains the data output register
`timescale 1ns/1ns
module lbs_sequencer_bench;
   import lbs_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, taken_w, call_w, full_w;
   lbs_instr_t instr = '0;
   lbs_ext_in_t ext_in;
   logic [9:0] pc_w, bp_w, cnt_w, ret_w, s_pl = 10'h155;
   // words with no output of their own repeat the last one given
   logic [15:0] co_w, dout_w, io_w, aux_w, ov = 16'hA5A5;
   lbs_flags_t fl_w;
   logic busy_w, aovf_w, bzero_w, sf = 1'b0;
   logic [4:0] s2 = 5'h00;
   int n_errors = 0, n_tests = 0, cycles = 0, i;
   logic [9:0] lp_pc [3] = '{10'h040, 10'h040, 10'h041};
   logic [9:0] lp_lc [3] = '{10'h001, 10'h000, 10'h3FF};
   always #5 clock = ~clock;
   lbs_sequencer u_dut (.clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid),
      .instr(instr), .ext_in(ext_in), .popped_loop_count(s_pl), .data_output_taken(taken_w),
      .busy(busy_w), .program_counter(pc_w), .control_out(co_w), .break_point(bp_w),
      .loop_counter(cnt_w), .arithmetic_flags(fl_w), .accumulator_overflow_flag(aovf_w),
      .block_counter_zero_flag(bzero_w), .data_output_register(dout_w),
      .data_output_full(full_w), .io_output_register(io_w), .aux_output_register(aux_w),
      .call_strobe(call_w),
      .return_address(ret_w));
   lbs_far_side u_far (.clock(clock), .sys_rst(sys_rst), .data_output_full(full_w),
      .data_output_taken(taken_w));
   task automatic wrap_up();
      if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one word, driven after one edge and taken at the next; effects read 1 ns later
   task automatic go(input lbs_flow_t f, input lbs_cpu_t c, input lbs_opr_t ds,
      input logic [4:0] di, input lbs_opr_t ss, input logic [4:0] si, input logic [15:0] k,
      input logic [9:0] a);
      @(posedge clock);
      instr_valid <= 1'b1;
      instr <= '{flow: f, cpu: c, dst_sel: ds, dst_idx: di, src_sel: ss, src_idx: si,
         src2_idx: s2, single_form: sf, imm_addr: a, constant: k, out_value: ov};
      @(posedge clock);
      instr_valid <= 1'b0;
      #1;
   endtask : go
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         wrap_up();
      end
   end
   initial begin
      ext_in = '{io_input: 16'h7777, aux_input: 16'h1111, swap_value: 16'h2222,
         data_input: 16'h3333};
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      go(FLOW_JUMP, CPU_COPY, OPR_GEN, 5'h01, OPR_CONST, 5'h00, 16'h0005, 10'h010);
      chk("control_out", co_w, 16'hA5A5);
      chk("pc", pc_w, 10'h010);
      chk("flags", fl_w, 4'h0);
      go(FLOW_CONTINUE, CPU_COPY, OPR_DATA_OUT, 5'h00, OPR_GEN, 5'h01, 16'h0, 10'h0);
      chk("data_out", dout_w, 16'h0005);
      chk("full", full_w, 1'b1);
      sf = 1'b1;
      go(FLOW_CONTINUE, CPU_NEGATE, OPR_GEN, 5'h01, OPR_GEN, 5'h00, 16'h0, 10'h0);
      chk("flags", fl_w, 4'h2);
      sf = 1'b0;
      go(FLOW_CONTINUE, CPU_COPY, OPR_DATA_OUT, 5'h00, OPR_GEN, 5'h01, 16'h0, 10'h0);
      chk("data_out", dout_w, 16'hFFFB);
      go(FLOW_CONTINUE, CPU_NEGATE, OPR_ACC_HI, 5'h00, OPR_CONST, 5'h00, 16'h8000, 10'h0);
      chk("flags", fl_w, 4'h3);
      chk("acc_ovf", aovf_w, 1'b1);
      go(FLOW_CONTINUE, CPU_NEGATE, OPR_BLOCK, 5'h00, OPR_CONST, 5'h00, 16'h0000, 10'h0);
      chk("flags", fl_w, 4'hC);
      chk("block_zero", bzero_w, 1'b1);
      go(FLOW_CONTINUE, CPU_COPY, OPR_DATA_OUT, 5'h00, OPR_IO_IN, 5'h00, 16'h0, 10'h0);
      chk("data_out", dout_w, 16'h7777);
      go(FLOW_CONTINUE, CPU_COPY, OPR_IO_OUT, 5'h00, OPR_SWAP, 5'h00, 16'h0, 10'h0);
      chk("io_out", io_w, 16'h2222);
      go(FLOW_CONTINUE, CPU_COPY, OPR_AUX_OUT, 5'h00, OPR_AUX_IN, 5'h00, 16'h0, 10'h0);
      chk("aux_out", aux_w, 16'h1111);
      go(FLOW_CONTINUE, CPU_COPY, OPR_ACC_LO, 5'h00, OPR_DATA_IN, 5'h00, 16'h0, 10'h0);
      chk("acc_ovf", aovf_w, 1'b0);
      go(FLOW_CONTINUE, CPU_COPY, OPR_BLOCK, 5'h00, OPR_CONST, 5'h00, 16'h0001, 10'h0);
      chk("block_zero", bzero_w, 1'b0);
      go(FLOW_CONTINUE, CPU_COPY, OPR_Q, 5'h00, OPR_ACC_LO, 5'h00, 16'h0, 10'h0);
      go(FLOW_CONTINUE, CPU_COPY, OPR_DATA_OUT, 5'h00, OPR_Q, 5'h00, 16'h0, 10'h0);
      chk("data_out", dout_w, 16'h3333);
      for (i = 0; i < 12 && full_w; i++) @(posedge clock);
      #1;
      chk("full", full_w, 1'b0);
      go(FLOW_LOAD_BREAK_IMM, CPU_NONE, OPR_GEN, 5'h00, OPR_CONST, 5'h00, 16'h0, 10'h3FF);
      chk("bp", bp_w, 10'h3FF);
      go(FLOW_LOAD_BREAK_COMP, CPU_COPY, OPR_CONST, 5'h00, OPR_CONST, 5'h00, 16'h1234, 10'h0);
      chk("bp", bp_w, 10'h234);
      go(FLOW_LOAD_BREAK_COMP, CPU_NONE, OPR_GEN, 5'h00, OPR_CONST, 5'h00, 16'h1234, 10'h0);
      chk("bp", bp_w, 10'h000);
      go(FLOW_LOAD_LOOP_IMM, CPU_NONE, OPR_GEN, 5'h00, OPR_CONST, 5'h00, 16'h0, 10'h002);
      for (i = 0; i < 3; i++) begin
         go(FLOW_LOOP_NZ, CPU_NONE, OPR_GEN, 5'h00, OPR_CONST, 5'h00, 16'h0, 10'h040);
         chk("pc", pc_w, lp_pc[i]);
         chk("loop_count", cnt_w, lp_lc[i]);
      end
      go(FLOW_LOAD_LOOP_COMP, CPU_COPY, OPR_CONST, 5'h00, OPR_CONST, 5'h00, 16'hFC05, 10'h0);
      chk("loop_count", cnt_w, 10'h005);
      go(FLOW_LOAD_LOOP_IMM, CPU_NONE, OPR_GEN, 5'h00, OPR_CONST, 5'h00, 16'h0, 10'h2AB);
      go(FLOW_JUMP_LOOP_PTR, CPU_NONE, OPR_GEN, 5'h00, OPR_CONST, 5'h00, 16'h0, 10'h0);
      chk("pc", pc_w, 10'h2AB);
      go(FLOW_CALL_LOOP_PTR, CPU_NONE, OPR_GEN, 5'h00, OPR_CONST, 5'h00, 16'h0, 10'h0);
      chk("call", call_w, 1'b1);
      chk("ret", ret_w, 10'h2AC);
      go(FLOW_POP_LOOP, CPU_NONE, OPR_GEN, 5'h00, OPR_CONST, 5'h00, 16'h0, 10'h0);
      chk("loop_count", cnt_w, 10'h155);
      go(FLOW_JUMP, CPU_COPY, OPR_GEN, 5'h03, OPR_CONST, 5'h00, 16'h0100, 10'h100);
      go(FLOW_CONTINUE, CPU_COPY, OPR_GEN, 5'h04, OPR_CONST, 5'h00, 16'h0300, 10'h0);
      // distinct sources keep the three-operand limits
      s2 = 5'h04;
      ov = 16'h1111;
      go(FLOW_JUMP, CPU_MULTIPLY, OPR_GEN, 5'h05, OPR_GEN, 5'h03, 16'h0, 10'h3C0);
      ov = 16'h2222;
      go(FLOW_CONTINUE, CPU_COPY, OPR_DATA_OUT, 5'h00, OPR_CONST, 5'h00, 16'hDEAD, 10'h0);
      chk("busy", busy_w, 1'b1);
      chk("control_out", co_w, 16'h1111);
      chk("data_out", dout_w, 16'h3333);
      for (i = 0; i < 30 && busy_w; i++) @(posedge clock);
      #1;
      chk("pc", pc_w, 10'h108);
      chk("flags", fl_w, 4'h0);
      go(FLOW_CONTINUE, CPU_COPY, OPR_DATA_OUT, 5'h00, OPR_GEN, 5'h05, 16'h0, 10'h0);
      chk("data_out", dout_w, 16'h0003);
      go(FLOW_CONTINUE, CPU_COPY, OPR_DATA_OUT, 5'h00, OPR_GEN, 5'h03, 16'h0, 10'h0);
      chk("data_out", dout_w, 16'h0000);
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("loop_count", cnt_w, 10'h000);
      chk("control_out", co_w, 16'h0000);
      wrap_up();
   end
endmodule : lbs_sequencer_bench
